/* File: rtl/pif_irq_flags.sv */
// Purpose: Peripheral interrupt flags, first enable register and request gate
// Assumes: Event inputs are one-cycle pulses on aclk; levels are on aclk too
// Notes:   Set beats software clear in the same cycle
// How it works
// - Conversion done sets bit 6, software clears
// - Bit 5 read-only, mirrors receive buffer full
// - Bit 4 read-only, mirrors transmit buffer empty
// - Serial port completion sets bit 3, sticky
// - Capture or compare sets bit 2, not PWM
// - Compare match sets capture/compare flag, held
// - Timer b period match sets bit 1
// - Timer a rollover sets bit 0
// - Unimplemented bits always read zero
// - Oscillator fail sets second register bit 7
// - Comparator one change sets bit 6
// - Comparator two change sets bit 5
// - Nonvolatile write done sets bit 4
// - Bus collision sets bit 3, sticky
// - Timer c rollover sets bit 1
// - Enable bits 6..0 gate matching flags
// - Without priorities, peripheral gate also required
// - Flags set regardless of any enable
// - Gate one passes, zero blocks all unless priority bit set
//
// Implementation choices: the AXI4-Lite slave port and the register addresses.
module pif_irq_flags (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        conv_done_evt,
  input  wire logic        rx_buffer_full,
  input  wire logic        tx_buffer_empty,
  input  wire logic        sync_serial_evt,
  input  wire logic        capture_evt,
  input  wire logic        compare_match_evt,
  input  wire logic        capcmp_pwm_mode,
  input  wire logic        timer_b_match_evt,
  input  wire logic        timer_a_ovf_evt,
  input  wire logic        osc_fail_evt,
  input  wire logic        comparator_one_out,
  input  wire logic        comparator_two_out,
  input  wire logic        nvm_write_evt,
  input  wire logic        bus_collision_evt,
  input  wire logic        timer_c_ovf_evt,
  output logic             peripheral_irq
);

  logic [7:0] flags1_r;
  logic [7:0] flags2_r;
  logic [7:0] enable1_r;
  logic [1:0] control_r;
  logic       cmp_one_r;
  logic       cmp_two_r;
  logic [7:0] hw_set1;
  logic [7:0] hw_set2;
  logic [7:0] sw_set1;
  logic [7:0] sw_clr1;
  logic [7:0] sw_set2;
  logic [7:0] sw_clr2;
  logic [7:0] flags1_nxt;
  logic [7:0] flags2_nxt;
  logic [7:0] flags1_view;
  logic       aw_held_r;
  logic       w_held_r;
  logic [3:0] awaddr_r;
  logic [31:0] wdata_r;
  logic       wstrb0_r;
  logic       do_write;
  logic       wr_flags1;
  logic       wr_flags2;
  logic       wr_enable1;
  logic       wr_control;
  logic       addr_ok;
  logic [7:0] rd_byte;
  logic       irq_nxt;

  // Write channel: address and data may arrive in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      awaddr_r  <= 4'h0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_r <= 1'b1;
      awaddr_r  <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r <= 1'b0;
      wdata_r  <= 32'h0000_0000;
      wstrb0_r <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_r <= 1'b1;
      wdata_r  <= s_axi_wdata;
      wstrb0_r <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_held_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_r && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready  <= !w_held_r && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  end

  assign do_write   = aw_held_r && w_held_r && !s_axi_bvalid;
  assign wr_flags1  = do_write && wstrb0_r && (awaddr_r == pif_pkg::FLAGS1_OFS);
  assign wr_flags2  = do_write && wstrb0_r && (awaddr_r == pif_pkg::FLAGS2_OFS);
  assign wr_enable1 = do_write && wstrb0_r && (awaddr_r == pif_pkg::ENABLE1_OFS);
  assign wr_control = do_write && wstrb0_r && (awaddr_r == pif_pkg::CONTROL_OFS);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= pif_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (awaddr_r[1:0] == 2'b00) ? pif_pkg::RESP_OKAY : pif_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Comparator outputs are registered so a change is seen as an edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp_one_r <= 1'b0;
      cmp_two_r <= 1'b0;
    end else begin
      cmp_one_r <= comparator_one_out;
      cmp_two_r <= comparator_two_out;
    end
  end

  // Hardware set terms never look at an enable
  always_comb begin
    hw_set1 = 8'h00;
    hw_set1[pif_pkg::CONV_DONE_BIT] = conv_done_evt;
    hw_set1[pif_pkg::SYNC_SER_BIT]  = sync_serial_evt;
    hw_set1[pif_pkg::CAPCMP_BIT]    = !capcmp_pwm_mode && (capture_evt || compare_match_evt);
    hw_set1[pif_pkg::TIMER_B_BIT]   = timer_b_match_evt;
    hw_set1[pif_pkg::TIMER_A_BIT]   = timer_a_ovf_evt;
    hw_set2 = 8'h00;
    hw_set2[pif_pkg::OSC_FAIL_BIT]  = osc_fail_evt;
    hw_set2[pif_pkg::CMP_ONE_BIT]   = comparator_one_out ^ cmp_one_r;
    hw_set2[pif_pkg::CMP_TWO_BIT]   = comparator_two_out ^ cmp_two_r;
    hw_set2[pif_pkg::NVM_WRITE_BIT] = nvm_write_evt;
    hw_set2[pif_pkg::BUS_COLL_BIT]  = bus_collision_evt;
    hw_set2[pif_pkg::TIMER_C_BIT]   = timer_c_ovf_evt;
  end

  // Software writes every writable bit of the byte; ones set, zeros clear
  assign sw_set1 = wr_flags1 ? (wdata_r[7:0] & pif_pkg::FLAGS1_SWMASK) : 8'h00;
  assign sw_clr1 = wr_flags1 ? (~wdata_r[7:0] & pif_pkg::FLAGS1_SWMASK) : 8'h00;
  assign sw_set2 = wr_flags2 ? (wdata_r[7:0] & pif_pkg::FLAGS2_MASK) : 8'h00;
  assign sw_clr2 = wr_flags2 ? (~wdata_r[7:0] & pif_pkg::FLAGS2_MASK) : 8'h00;

  // Set wins over clear
  assign flags1_nxt = ((flags1_r & ~sw_clr1) | sw_set1 | hw_set1) & pif_pkg::FLAGS1_SWMASK;
  assign flags2_nxt = ((flags2_r & ~sw_clr2) | sw_set2 | hw_set2) & pif_pkg::FLAGS2_MASK;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags1_r <= pif_pkg::FLAGS_RST;
      flags2_r <= pif_pkg::FLAGS_RST;
    end else begin
      flags1_r <= flags1_nxt;
      flags2_r <= flags2_nxt;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable1_r <= pif_pkg::ENABLE_RST;
      control_r <= 2'b00;
    end else begin
      if (wr_enable1) begin
        enable1_r <= wdata_r[7:0] & pif_pkg::ENABLE1_MASK;
      end
      if (wr_control) begin
        control_r <= wdata_r[1:0];
      end
    end
  end

  // Buffer status bits follow the serial port live; software cannot write them
  always_comb begin
    flags1_view = flags1_r;
    flags1_view[pif_pkg::RX_FULL_BIT]  = rx_buffer_full;
    flags1_view[pif_pkg::TX_EMPTY_BIT] = tx_buffer_empty;
  end

  // Priority mode hands the gate bit to the low-priority path outside this block
  always_comb begin
    irq_nxt = |(flags1_view & enable1_r & pif_pkg::ENABLE1_MASK);
    if (!control_r[pif_pkg::PRIO_BIT]) begin
      irq_nxt = irq_nxt && control_r[pif_pkg::GATE_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      peripheral_irq <= 1'b0;
    end else begin
      peripheral_irq <= irq_nxt;
    end
  end

  // Read channel
  assign addr_ok = (s_axi_araddr[1:0] == 2'b00);

  always_comb begin
    case (s_axi_araddr)
      pif_pkg::FLAGS1_OFS:  rd_byte = flags1_view & pif_pkg::FLAGS1_MASK;
      pif_pkg::FLAGS2_OFS:  rd_byte = flags2_r & pif_pkg::FLAGS2_MASK;
      pif_pkg::ENABLE1_OFS: rd_byte = enable1_r & pif_pkg::ENABLE1_MASK;
      pif_pkg::CONTROL_OFS: rd_byte = {6'b00_0000, control_r};
      default:              rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= pif_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h00_0000, rd_byte};
      s_axi_rresp   <= addr_ok ? pif_pkg::RESP_OKAY : pif_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // Checks
  a_flag_timer_a: assert property (@(posedge aclk) disable iff (!aresetn)
    timer_a_ovf_evt |=> flags1_r[pif_pkg::TIMER_A_BIT])
    else $error("timer a flag not set");
  a_flag_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    flags1_r[pif_pkg::CONV_DONE_BIT] && !wr_flags1 |=> flags1_r[pif_pkg::CONV_DONE_BIT])
    else $error("conversion flag lost");
  a_capcmp_pwm: assert property (@(posedge aclk) disable iff (!aresetn)
    capcmp_pwm_mode && !flags1_r[pif_pkg::CAPCMP_BIT] && !wr_flags1 |=> !flags1_r[pif_pkg::CAPCMP_BIT])
    else $error("capture flag set in pwm mode");
  // The flag follows the change by one edge; the edge detector compares with the registered copy in the same cycle
  a_cmp_change: assert property (@(posedge aclk) disable iff (!aresetn)
    $changed(comparator_one_out) |=> flags2_r[pif_pkg::CMP_ONE_BIT])
    else $error("comparator one change missed");
  a_unimpl_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(s_axi_rvalid) |-> s_axi_rdata[31:8] == 24'h00_0000
      && (!s_axi_rdata[7] || $past(s_axi_araddr) == pif_pkg::FLAGS2_OFS)
      && ($past(s_axi_araddr) != pif_pkg::FLAGS2_OFS || (!s_axi_rdata[2] && !s_axi_rdata[0])))
    else $error("unimplemented bit read one");
  a_gate_block: assert property (@(posedge aclk) disable iff (!aresetn)
    !control_r[pif_pkg::GATE_BIT] && !control_r[pif_pkg::PRIO_BIT] |=> !peripheral_irq)
    else $error("request passed closed gate");
  a_irq_raise: assert property (@(posedge aclk) disable iff (!aresetn)
    (flags1_r[pif_pkg::TIMER_A_BIT] && enable1_r[pif_pkg::TIMER_A_BIT] && control_r[pif_pkg::GATE_BIT]) |=> peripheral_irq)
    else $error("request not raised");
  a_enable_mask: assert property (@(posedge aclk) disable iff (!aresetn)
    enable1_r == 8'h00 |=> !peripheral_irq)
    else $error("request with no enables");
  // Read data is captured at the address edge, so it reflects the level one edge back
  a_rx_mirror: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(s_axi_rvalid) && $past(s_axi_araddr) == pif_pkg::FLAGS1_OFS
      |-> s_axi_rdata[pif_pkg::RX_FULL_BIT] == $past(rx_buffer_full))
    else $error("receive flag not live");
  a_tx_mirror: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(s_axi_rvalid) && $past(s_axi_araddr) == pif_pkg::FLAGS1_OFS
      |-> s_axi_rdata[pif_pkg::TX_EMPTY_BIT] == $past(tx_buffer_empty))
    else $error("transmit flag not live");
  a_set_wins: assert property (@(posedge aclk) disable iff (!aresetn)
    bus_collision_evt && wr_flags2 |=> flags2_r[pif_pkg::BUS_COLL_BIT])
    else $error("event lost on clear");

  // Every event source lands in its flag one edge later; capture and compare share one flag and land only outside PWM mode
  a_conv_done: assert property (@(posedge aclk) disable iff (!aresetn)
    conv_done_evt |=> flags1_r[pif_pkg::CONV_DONE_BIT])
    else $error("conversion flag not set");
  a_sync_serial: assert property (@(posedge aclk) disable iff (!aresetn)
    sync_serial_evt |=> flags1_r[pif_pkg::SYNC_SER_BIT])
    else $error("serial port flag not set");
  a_capture_hit: assert property (@(posedge aclk) disable iff (!aresetn)
    !capcmp_pwm_mode && capture_evt |=> flags1_r[pif_pkg::CAPCMP_BIT])
    else $error("capture flag not set");
  a_compare_hit: assert property (@(posedge aclk) disable iff (!aresetn)
    !capcmp_pwm_mode && compare_match_evt |=> flags1_r[pif_pkg::CAPCMP_BIT])
    else $error("compare flag not set");
  a_timer_b: assert property (@(posedge aclk) disable iff (!aresetn)
    timer_b_match_evt |=> flags1_r[pif_pkg::TIMER_B_BIT])
    else $error("timer b flag not set");
  a_osc_fail: assert property (@(posedge aclk) disable iff (!aresetn)
    osc_fail_evt |=> flags2_r[pif_pkg::OSC_FAIL_BIT])
    else $error("oscillator flag not set");
  a_cmp_two: assert property (@(posedge aclk) disable iff (!aresetn)
    $changed(comparator_two_out) |=> flags2_r[pif_pkg::CMP_TWO_BIT])
    else $error("comparator two change missed");
  a_nvm_write: assert property (@(posedge aclk) disable iff (!aresetn)
    nvm_write_evt |=> flags2_r[pif_pkg::NVM_WRITE_BIT])
    else $error("write done flag not set");
  a_bus_coll: assert property (@(posedge aclk) disable iff (!aresetn)
    bus_collision_evt |=> flags2_r[pif_pkg::BUS_COLL_BIT])
    else $error("collision flag not set");
  a_timer_c: assert property (@(posedge aclk) disable iff (!aresetn)
    timer_c_ovf_evt |=> flags2_r[pif_pkg::TIMER_C_BIT])
    else $error("timer c flag not set");

  // Software side of the flags: a written one sets, a written zero clears
  a_sw_set: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_flags2 && wdata_r[pif_pkg::TIMER_C_BIT] |=> flags2_r[pif_pkg::TIMER_C_BIT])
    else $error("software set ignored");
  a_sw_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_flags1 && !wdata_r[pif_pkg::TIMER_A_BIT] && !timer_a_ovf_evt |=> !flags1_r[pif_pkg::TIMER_A_BIT])
    else $error("software clear ignored");

  // Request gating
  a_prio_bypass: assert property (@(posedge aclk) disable iff (!aresetn)
    control_r[pif_pkg::PRIO_BIT] && flags1_r[pif_pkg::TIMER_A_BIT] && enable1_r[pif_pkg::TIMER_A_BIT]
      |=> peripheral_irq)
    else $error("request lost in priority mode");
  a_irq_drop: assert property (@(posedge aclk) disable iff (!aresetn)
    !(|(flags1_view & enable1_r)) |=> !peripheral_irq)
    else $error("request without enabled flag");

  // Checked while reset is low, so this one has no disable
  a_reset_clear: assert property (@(posedge aclk)
    !aresetn |=> flags1_r == 8'h00 && flags2_r == 8'h00 && enable1_r == 8'h00 && !peripheral_irq)
    else $error("reset left state behind");

  c_write_resp: cover property (@(posedge aclk) disable iff (!aresetn) s_axi_bvalid && s_axi_bready);
  c_read_resp: cover property (@(posedge aclk) disable iff (!aresetn) s_axi_rvalid && s_axi_rready);
  c_irq_up: cover property (@(posedge aclk) disable iff (!aresetn) $rose(peripheral_irq));
  c_set_clear: cover property (@(posedge aclk) disable iff (!aresetn) timer_c_ovf_evt && wr_flags2);
  c_pwm_block: cover property (@(posedge aclk) disable iff (!aresetn) capcmp_pwm_mode && capture_evt);

endmodule : pif_irq_flags

/* File: common/pif_pkg.sv */
// Purpose: Constants for the peripheral interrupt flag and enable block
// Assumes: AXI4-Lite slave, 32-bit data, one register per aligned word
// Notes:   Registers hold up to 8 bits in the low byte; upper bits read zero
package pif_pkg;
  localparam logic [3:0] FLAGS1_OFS    = 4'h0;
  localparam logic [3:0] FLAGS2_OFS    = 4'h4;
  localparam logic [3:0] ENABLE1_OFS   = 4'h8;
  localparam logic [3:0] CONTROL_OFS   = 4'hC;
  // Implemented bits of each register
  localparam logic [7:0] FLAGS1_MASK   = 8'h7F;
  localparam logic [7:0] FLAGS1_SWMASK = 8'h4F;
  localparam logic [7:0] FLAGS2_MASK   = 8'hFA;
  localparam logic [7:0] ENABLE1_MASK  = 8'h7F;
  localparam logic [7:0] FLAGS_RST     = 8'h00;
  localparam logic [7:0] ENABLE_RST    = 8'h00;
  // Flag positions, first flag register
  localparam int CONV_DONE_BIT  = 6;
  localparam int RX_FULL_BIT    = 5;
  localparam int TX_EMPTY_BIT   = 4;
  localparam int SYNC_SER_BIT   = 3;
  localparam int CAPCMP_BIT     = 2;
  localparam int TIMER_B_BIT    = 1;
  localparam int TIMER_A_BIT    = 0;
  // Flag positions, second flag register
  localparam int OSC_FAIL_BIT   = 7;
  localparam int CMP_ONE_BIT    = 6;
  localparam int CMP_TWO_BIT    = 5;
  localparam int NVM_WRITE_BIT  = 4;
  localparam int BUS_COLL_BIT   = 3;
  localparam int TIMER_C_BIT    = 1;
  // Control register fields
  localparam int GATE_BIT       = 0;
  localparam int PRIO_BIT       = 1;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : pif_pkg

/* File: bench/pif_periph_model.sv */
// Purpose: Peripheral side model raising event pulses and comparator levels
// Assumes: Requests arrive from the bench on aclk as fire plus an index
// Notes:   Indices 0..9 are event pulses, 10 and 11 toggle the comparators
module pif_periph_model (
  input  wire logic       aclk,
  input  wire logic       fire,
  input  wire logic [3:0] sel,
  output logic [9:0]      pulse,
  output logic            cmp_one,
  output logic            cmp_two
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    pulse = '0;
    cmp_one = 1'b0;
    cmp_two = 1'b0;
  end
  // Pulses last one cycle per cycle of fire, so a held request repeats the event every cycle
  always @(posedge aclk) begin
    pulse <= '0;
    if (fire && sel < 4'd10) pulse[sel] <= 1'b1;
    if (fire && sel == 4'd10) cmp_one <= ~cmp_one;
    if (fire && sel == 4'd11) cmp_two <= ~cmp_two;
  end
endmodule : pif_periph_model

/* File: bench/tb_peripheral_irq_flags_enables.sv */
// Purpose: Self-checking bench for the peripheral flag and enable block
// Assumes: AXI4-Lite master in tasks; offsets 0x0, 0x4, 0x8, 0xC
// Notes:   Only the first flag register reaches the request; flags2 has no enable here
module tb_peripheral_irq_flags_enables;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic        rx_lvl, tx_lvl, pwm, fire, cmp_one, cmp_two;
  logic [3:0]  awaddr, araddr, wstrb, sel;
  logic [31:0] wdata, rdata, d;
  logic [1:0]  bresp, rresp, r;
  logic [9:0]  pulse;
  int          mismatches, n_compared, f1, f2, en, ct;
  int          rg[12] = '{1, 1, 1, 1, 1, 1, 2, 2, 2, 2, 2, 2};
  int          bt[12] = '{6, 3, 2, 2, 1, 0, 7, 4, 3, 1, 6, 5};

  pif_irq_flags dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .conv_done_evt(pulse[0]), .rx_buffer_full(rx_lvl),
    .tx_buffer_empty(tx_lvl), .sync_serial_evt(pulse[1]), .capture_evt(pulse[2]), .compare_match_evt(pulse[3]),
    .capcmp_pwm_mode(pwm), .timer_b_match_evt(pulse[4]), .timer_a_ovf_evt(pulse[5]), .osc_fail_evt(pulse[6]),
    .comparator_one_out(cmp_one), .comparator_two_out(cmp_two), .nvm_write_evt(pulse[7]),
    .bus_collision_evt(pulse[8]), .timer_c_ovf_evt(pulse[9]), .peripheral_irq(irq));
  pif_periph_model periph (.aclk(aclk), .fire(fire), .sel(sel), .pulse(pulse), .cmp_one(cmp_one), .cmp_two(cmp_two));

  always #4 aclk = ~aclk;

  task automatic end_of_test;
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp

  task automatic hang(input string what);
    mismatches++;
    $display("MISMATCH t=%0t %s timed out", $time, what);
    end_of_test();
  endtask : hang

  task automatic wr(input logic [3:0] a, input logic [31:0] v, input logic [3:0] s, output logic [1:0] resp);
    bit ad, wd;
    ad = 0;
    wd = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (ad && wd && bvalid) begin
        resp = bresp;
        bready <= 1'b0;
        return;
      end
      if (!ad && awready) begin
        ad = 1;
        awvalid <= 1'b0;
      end
      if (!wd && wready) begin
        wd = 1;
        wvalid <= 1'b0;
      end
    end
    hang("write");
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] resp);
    bit ad;
    ad = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (ad && rvalid) begin
        v = rdata;
        resp = rresp;
        rready <= 1'b0;
        return;
      end
      if (!ad && arready) begin
        ad = 1;
        arvalid <= 1'b0;
      end
    end
    hang("read");
  endtask : rd

  task automatic ev(input int k);
    @(posedge aclk);
    fire <= 1'b1;
    sel <= 4'(k);
    @(posedge aclk);
    fire <= 1'b0;
    if (!(pwm && (k == 2 || k == 3))) begin
      if (rg[k] == 1) f1 |= 1 << bt[k];
      else f2 |= 1 << bt[k];
    end
  endtask : ev

  task automatic mwr(input logic [3:0] a, input logic [31:0] v, input logic [3:0] s);
    wr(a, v, s, r);
    cmp(32'(r), 32'(pif_pkg::RESP_OKAY), "bresp");
    if (s[0]) begin
      case (a)
        4'h0: f1 = v & 'h4F;
        4'h4: f2 = v & 'hFA;
        4'h8: en = v & 'h7F;
        default: ct = v & 3;
      endcase
    end
  endtask : mwr

  task automatic check_all;
    int e[4];
    repeat (4) @(posedge aclk);
    e[0] = f1 | (int'(rx_lvl) << 5) | (int'(tx_lvl) << 4);
    e[1] = f2;
    e[2] = en;
    e[3] = ct;
    cmp({31'b0, irq}, 32'((ct[1] || ct[0]) && ((e[0] & en) != 0)), "irq");
    for (int i = 0; i < 4; i++) begin
      rd(4'(i * 4), d, r);
      cmp(d, 32'(e[i]), "register");
      cmp(32'(r), 32'(pif_pkg::RESP_OKAY), "rresp");
    end
  endtask : check_all

  initial begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, rx_lvl, tx_lvl, pwm, fire} = '0;
    {awaddr, araddr, wstrb, sel, wdata} = '0;
    {mismatches, n_compared, f1, f2, en, ct} = '0;
    void'($urandom(32'he398));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    check_all();
    mwr(4'h0, 32'h0000_0000, 4'hF);
    mwr(4'h8, 32'h0000_00FF, 4'hF);
    mwr(4'hC, 32'h0000_0001, 4'hF);
    wr(4'h6, 32'h0000_00FF, 4'hF, r);
    cmp(32'(r), 32'(pif_pkg::RESP_SLVERR), "bad write");
    rd(4'h1, d, r);
    cmp(32'(r), 32'(pif_pkg::RESP_SLVERR), "bad read");
    cmp(d, 32'h0000_0000, "bad read data");
    for (int k = 0; k < 12; k++) begin
      ev(k);
      check_all();
    end
    for (int i = 0; i < 80; i++) begin
      case ($urandom % 4)
        0, 1: ev(int'($urandom % 12));
        2: mwr(4'($urandom % 4 * 4), $urandom, 4'($urandom));
        default: begin
          @(posedge aclk);
          rx_lvl <= 1'($urandom);
          tx_lvl <= 1'($urandom);
          pwm <= 1'($urandom);
        end
      endcase
      check_all();
    end
    end_of_test();
  end
endmodule : tb_peripheral_irq_flags_enables
